// *** core/bcg_bank.sv ***
// Bridge control, discard timer and GPIO register bank with Wishbone slave
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Forward mode: enabled secondary errors become messages
// - Reverse mode: forwarding enable ignores writes
// - Forward mode: reset bit drives secondary reset
// - Reverse mode: reset bit makes link hot reset
// - VGA field 00: claim no VGA traffic
// - VGA field 01: forward primary to secondary
// - VGA field 10: forward secondary to primary
// - VGA I/O decode 10 or 16 bits
// - Hidden master abort: all-ones reads, drop writes
// - Reported master abort: target abort else error
// - Primary discard timer 2^15 or 2^10 cycles
// - Forward mode: primary timeout bit read-only, ignored
// - Secondary discard timer 2^15 or 2^10 cycles
// - Reverse mode: secondary timeout bit read-only, ignored
// - Timeout status sticky until written one
// - Timer expiry raises message or system error
// - GPIO output write-one set and clear
// - GPIO enable write-one set and clear
// - GPIO input field reads sampled pins
module bcg_bank
  import bcg_pkg::*;
#(
  parameter int DT_LONG_CYC = BCG_DT_LONG_CYC // Long discard length, shorten in simulation
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Bridge mode strap and pins
  input wire logic reverse_mode,
  input wire logic sec_syserr_n,
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe,
  output logic sec_bus_reset_n,
  output logic link_hot_reset,
  output logic system_error_n,
  // Error message request toward the link
  input wire logic err_fatal_sel,
  input wire logic serr_enable,
  output logic err_msg,
  output logic err_msg_fatal,
  // VGA decode
  input wire bcg_vga_req_t vga_req,
  output logic vga_claim,
  // Master abort handling
  input wire logic ma_event,
  input wire logic ma_is_read,
  input wire logic ma_ta_possible,
  output logic ma_target_abort,
  output logic ma_fill_ones,
  output logic ma_drop_write,
  // Delayed completion waiting, one per side (0 primary, 1 secondary)
  input wire logic [1:0] dc_pending,
  output logic [1:0] dc_discard
);

  // Reset release chain
  logic [1:0] rst_sync_r;
  logic rst_n;

  // Async assert, clocked release so the bank leaves reset cleanly
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Pin synchronisers: stage one is read only by stage two
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic serr_d_r; // Previous synced error level, for edge detect
  wire rev = pin_s2_r[5];
  wire serr_sync_n = pin_s2_r[4];
  wire [3:0] gpio_sync = pin_s2_r[3:0];

  // Two flops per outside pin
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 6'h30;
      pin_s2_r <= 6'h30;
      serr_d_r <= 1'b1;
    end else if (clk_en) begin
      pin_s1_r <= {reverse_mode, sec_syserr_n, gpio_in};
      pin_s2_r <= pin_s1_r;
      serr_d_r <= serr_sync_n;
    end
  end

  // Bus decode
  logic ack_r;
  wire req = wb_cyc_i & wb_stb_i;
  wire hit_ctl = (wb_adr_i[7:2] == BCG_OFF_CTRL[7:2]);
  // A write lands on the edge where the master sees ack
  wire wr_fire = req & wb_we_i & ack_r;
  wire wr_ctl = wr_fire & hit_ctl;
  wire [31:0] be = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wmask = wr_ctl ? (be & wb_dat_i) : BCG_ZERO;
  wire [31:0] wval = be & wb_dat_i;

  // Control state
  bcg_ctl_t ctl_r;
  bcg_ctl_t ctl_nxt;
  logic [3:0] gpo_r;
  logic [3:0] gpo_nxt;
  logic [3:0] gpoe_r;
  logic [3:0] gpoe_nxt;
  logic [1:0] dt_exp; // Timer expiry strobes

  // Next value of the control bits
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_ctl && wb_sel_i[0]) begin
      if (!rev) begin
        ctl_nxt.syserr_forwarding_enable = wval[BCG_B_SERR_FWD];
      end
      ctl_nxt.sec_rst = wval[BCG_B_SEC_RST];
      ctl_nxt.vga_en = wval[BCG_B_VGA_LO +: 2];
      ctl_nxt.vga16 = wval[BCG_B_VGA16];
      ctl_nxt.ma_mode = wval[BCG_B_MA_MODE];
    end
    if (wr_ctl && wb_sel_i[1]) begin
      // primary timeout bit frozen in forward
      if (rev) begin
        ctl_nxt.pri_mto = wval[BCG_B_PRI_MTO];
      end
      // secondary timeout bit frozen in reverse
      if (!rev) begin
        ctl_nxt.sec_mto = wval[BCG_B_SEC_MTO];
      end
      ctl_nxt.discard_error_signal_enable = wval[BCG_B_DT_ERR];
    end
    // sticky status, a new expiry beats the clear
    // a written zero keeps the status
    ctl_nxt.mto_sts = (|dt_exp) | (ctl_r.mto_sts & ~wmask[BCG_B_MTO_STS]);
  end

  // output set and clear, set wins on a clash
  assign gpo_nxt = (gpo_r & ~wmask[BCG_B_GPO_CLR +: 4]) | wmask[BCG_B_GPO_SET +: 4];
  assign gpoe_nxt = (gpoe_r & ~wmask[BCG_B_GPOE_CLR +: 4]) | wmask[BCG_B_GPOE_SET +: 4];

  // Register update, short on purpose
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= '0;
      gpo_r <= BCG_GPIO_RST;
      gpoe_r <= BCG_GPIO_RST;
    end else if (clk_en) begin
      ctl_r <= ctl_nxt;
      gpo_r <= gpo_nxt;
      gpoe_r <= gpoe_nxt;
    end
  end

  // Read data mux; the set/clear nibbles read back the live state
  wire [31:0] ctl_word = {gpio_sync, gpoe_r, gpoe_r, gpo_r, gpo_r,
                          ctl_r.discard_error_signal_enable, ctl_r.mto_sts, ctl_r.sec_mto,
                          ctl_r.pri_mto, ctl_r.ma_mode, ctl_r.vga16, ctl_r.vga_en,
                          ctl_r.sec_rst, ctl_r.syserr_forwarding_enable, 2'h0};
  // input nibble is the synced pin level
  wire [31:0] rd_word = hit_ctl ? ctl_word : BCG_ZERO;

  // One wait state, ack drops the cycle after it was given
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      wb_dat_o <= BCG_ZERO;
    end else if (clk_en) begin
      ack_r <= req & ~ack_r;
      wb_dat_o <= (req & ~ack_r & ~wb_we_i) ? rd_word : BCG_ZERO;
    end
  end
  assign wb_ack_o = ack_r;

  // Discard timers, one per side
  logic [BCG_DT_W-1:0] dt_cnt_r [2];
  logic [1:0] dt_short;
  // Forward ignores primary bit, reverse ignores secondary bit
  // primary select forced long in forward
  assign dt_short[0] = rev & ctl_r.pri_mto;
  // secondary select forced long in reverse
  assign dt_short[1] = ~rev & ctl_r.sec_mto;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dt
      wire [BCG_DT_W-1:0] lim = dt_short[gi] ? BCG_DT_W'(BCG_DT_SHORT_CYC - 1)
                                             : BCG_DT_W'(DT_LONG_CYC - 1);
      // expiry after the selected cycle count
      assign dt_exp[gi] = clk_en & dc_pending[gi] & (dt_cnt_r[gi] == lim);
      // Count while a completion waits, restart on expiry or pickup
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          dt_cnt_r[gi] <= '0;
        end else if (clk_en) begin
          if (!dc_pending[gi] || dt_exp[gi]) begin
            dt_cnt_r[gi] <= '0;
          end else begin
            dt_cnt_r[gi] <= dt_cnt_r[gi] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // Event decode
  wire serr_fall = serr_d_r & ~serr_sync_n;
  // forward mode conversion of secondary system errors
  wire fwd_serr = ~rev & ctl_r.syserr_forwarding_enable & serr_fall;
  // expiry error, message forward or system error reverse
  wire dt_err = (|dt_exp) & ctl_r.discard_error_signal_enable;
  wire ma_rep = ma_event & ctl_r.ma_mode;
  // target abort when possible, else system error if enabled
  wire ma_serr = ma_rep & ~ma_ta_possible & serr_enable;
  wire msg_go = fwd_serr | (dt_err & ~rev);
  wire serr_go = (dt_err & rev) | ma_serr;

  // VGA decode
  wire vga_mem = (vga_req.addr[31:17] == 15'h0005);
  wire [9:0] a10 = vga_req.addr[9:0];
  wire vga_io_lo = ((a10 >= 10'h3B0) && (a10 <= 10'h3BB)) ||
                   ((a10 >= 10'h3C0) && (a10 <= 10'h3DF));
  // upper bits must be zero only for 16-bit decode
  wire vga_io = vga_io_lo & (~ctl_r.vga16 | (vga_req.addr[15:10] == 6'h00));
  wire vga_hit = vga_req.valid & (vga_req.is_io ? vga_io : vga_mem);
  // direction gate, 00 and 11 claim nothing
  wire vga_dir = ((ctl_r.vga_en == BCG_VGA_P2S) & ~vga_req.from_sec) |
                 ((ctl_r.vga_en == BCG_VGA_S2P) & vga_req.from_sec);

  // Registered outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_bus_reset_n <= 1'b1;
      link_hot_reset <= 1'b0;
      system_error_n <= 1'b1;
      err_msg <= 1'b0;
      err_msg_fatal <= 1'b0;
      vga_claim <= 1'b0;
      ma_target_abort <= 1'b0;
      ma_fill_ones <= 1'b0;
      ma_drop_write <= 1'b0;
      dc_discard <= 2'h0;
      gpio_out <= BCG_GPIO_RST;
      gpio_oe <= BCG_GPIO_RST;
    end else if (clk_en) begin
      // secondary bus reset held while the bit is set in forward mode
      sec_bus_reset_n <= ~(ctl_r.sec_rst & ~rev);
      // link hot reset in reverse mode
      link_hot_reset <= ctl_r.sec_rst & rev;
      system_error_n <= ~serr_go;
      err_msg <= msg_go;
      err_msg_fatal <= msg_go & err_fatal_sel;
      vga_claim <= vga_hit & vga_dir;
      ma_target_abort <= ma_rep & ma_ta_possible;
      // hidden abort: fill reads, drop writes
      ma_fill_ones <= ma_event & ~ctl_r.ma_mode & ma_is_read;
      ma_drop_write <= ma_event & ~ctl_r.ma_mode & ~ma_is_read;
      dc_discard <= dt_exp;
      gpio_out <= gpo_r;
      gpio_oe <= gpoe_r;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_serr_edge;
    clk_en && !rev && ctl_r.syserr_forwarding_enable && serr_fall;
  endsequence
  sequence s_one_msg;
    err_msg;
  endsequence

  a_serr_forward: assert property (
    s_serr_edge |=> s_one_msg)
    else $error("secondary error not forwarded");

  a_fwd_bit_frozen: assert property (
    (clk_en && rev) |=>
      (ctl_r.syserr_forwarding_enable == $past(ctl_r.syserr_forwarding_enable)))
    else $error("forwarding enable changed in reverse mode");

  a_sec_reset_pin: assert property (
    (clk_en && !rev && ctl_r.sec_rst) |=> !sec_bus_reset_n)
    else $error("secondary reset not driven");

  a_hot_reset: assert property (
    (clk_en && rev && ctl_r.sec_rst) |=> link_hot_reset)
    else $error("hot reset missing in reverse mode");

  a_vga_off: assert property (
    (clk_en && ctl_r.vga_en == BCG_VGA_OFF) |=> !vga_claim)
    else $error("VGA claimed while disabled");

  a_vga_p2s: assert property (
    (clk_en && ctl_r.vga_en == BCG_VGA_P2S && vga_req.from_sec) |=> !vga_claim)
    else $error("secondary VGA claimed in primary-to-secondary mode");

  a_vga_s2p: assert property (
    (clk_en && ctl_r.vga_en == BCG_VGA_S2P && vga_req.valid && vga_req.from_sec
     && !vga_req.is_io && vga_mem) |=> vga_claim)
    else $error("secondary VGA memory not claimed");

  a_vga_alias: assert property (
    (clk_en && ctl_r.vga16 && vga_req.is_io && vga_req.addr[15:10] != 6'h00) |=> !vga_claim)
    else $error("16-bit decode claimed an alias");

  a_ma_hidden: assert property (
    (clk_en && ma_event && !ctl_r.ma_mode) |=> !ma_target_abort && system_error_n)
    else $error("hidden master abort was reported");

  a_ma_report: assert property (
    (clk_en && ma_event && ctl_r.ma_mode && ma_ta_possible) |=> ma_target_abort)
    else $error("master abort not reported as target abort");

  a_pri_short: assert property (
    (clk_en && dt_short[0] && dc_pending[0]
     && dt_cnt_r[0] == BCG_DT_W'(BCG_DT_SHORT_CYC - 1)) |=> dc_discard[0])
    else $error("primary short timer wrong length");

  a_pri_ignored: assert property (
    (!rev && dt_exp[0]) |-> dt_cnt_r[0] == BCG_DT_W'(DT_LONG_CYC - 1))
    else $error("primary short timer used in forward mode");

  a_sec_short: assert property (
    (clk_en && dt_short[1] && dc_pending[1]
     && dt_cnt_r[1] == BCG_DT_W'(BCG_DT_SHORT_CYC - 1)) |=> dc_discard[1])
    else $error("secondary short timer wrong length");

  a_sec_ignored: assert property (
    (rev && dt_exp[1]) |-> dt_cnt_r[1] == BCG_DT_W'(DT_LONG_CYC - 1))
    else $error("secondary short timer used in reverse mode");

  a_status_sticky: assert property (
    (clk_en && |dt_exp) |=> ctl_r.mto_sts)
    else $error("timeout status not set");

  a_dt_serr: assert property (
    (clk_en && rev && ctl_r.discard_error_signal_enable && |dt_exp) |=> !system_error_n)
    else $error("discard expiry did not assert system error");

  a_gpio_set: assert property (
    (clk_en && wr_ctl && wb_sel_i[2] && wb_dat_i[BCG_B_GPO_SET]) |=> ##1 gpio_out[0])
    else $error("GPIO set did not reach the pin");

  a_gpoe_clr: assert property (
    (clk_en && wr_ctl && wb_sel_i[2] && wb_dat_i[BCG_B_GPOE_CLR]
     && !(wb_sel_i[3] && wb_dat_i[BCG_B_GPOE_SET])) |=> ##1 !gpio_oe[0])
    else $error("GPIO enable clear did not reach the pin");

  a_gpi_read: assert property (
    (clk_en && req && !ack_r && !wb_we_i && hit_ctl) |=> wb_dat_o[31:28] == $past(gpio_sync))
    else $error("GPIO input field wrong");

  a_zero_keeps: assert property (
    (clk_en && wr_ctl && !wb_dat_i[BCG_B_MTO_STS] && ctl_r.mto_sts) |=> ctl_r.mto_sts)
    else $error("written zero cleared the status");

endmodule

`default_nettype wire

// *** core/bcg_pkg.sv ***
// Constants and types shared by the bridge control and GPIO register bank
package bcg_pkg;
  // Word offsets of the bank, byte addresses on the bus
  localparam logic [7:0] BCG_OFF_RSVD = 8'h74;
  localparam logic [7:0] BCG_OFF_CTRL = 8'h78;
  // Bridge control field positions
  localparam int BCG_B_SERR_FWD = 2;
  localparam int BCG_B_SEC_RST = 3;
  localparam int BCG_B_VGA_LO = 4;
  localparam int BCG_B_VGA16 = 6;
  localparam int BCG_B_MA_MODE = 7;
  localparam int BCG_B_PRI_MTO = 8;
  localparam int BCG_B_SEC_MTO = 9;
  localparam int BCG_B_MTO_STS = 10;
  localparam int BCG_B_DT_ERR = 11;
  // GPIO field positions (low bit of each nibble)
  localparam int BCG_B_GPO_CLR = 12;
  localparam int BCG_B_GPO_SET = 16;
  localparam int BCG_B_GPOE_CLR = 20;
  localparam int BCG_B_GPOE_SET = 24;
  localparam int BCG_B_GPI = 28;
  localparam int BCG_GPIO_N = 4;
  // Reset values, everything comes up zero
  localparam logic [3:0] BCG_GPIO_RST = 4'h0;
  localparam logic [1:0] BCG_VGA_RST = 2'h0;
  // VGA enable encodings
  localparam logic [1:0] BCG_VGA_OFF = 2'h0;
  localparam logic [1:0] BCG_VGA_P2S = 2'h1;
  localparam logic [1:0] BCG_VGA_S2P = 2'h2;
  // Discard timer lengths in PCI clock cycles
  localparam int BCG_DT_LONG_CYC = 2 ** 15;
  localparam int BCG_DT_SHORT_CYC = 2 ** 10;
  localparam int BCG_DT_W = 16;
  // Hidden master-abort reads and unmapped reads
  localparam logic [31:0] BCG_ALL_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] BCG_ZERO = 32'h00000000;

  // Software-held bridge control bits
  typedef struct packed {
    logic discard_error_signal_enable;
    logic mto_sts;
    logic sec_mto;
    logic pri_mto;
    logic ma_mode;
    logic vga16;
    logic [1:0] vga_en;
    logic sec_rst;
    logic syserr_forwarding_enable;
  } bcg_ctl_t;

  // One transaction offered for VGA decode
  typedef struct packed {
    logic valid;
    logic is_io;
    logic from_sec;
    logic [31:0] addr;
  } bcg_vga_req_t;
endpackage

// *** test/tb_bcg_bank.sv ***
// Self-checking bench for the bridge control and GPIO register bank
`timescale 1ns/1ps
`default_nettype none
module tb_bcg_bank
  import bcg_pkg::*;
;
  localparam int LONG = 64; // Shortened long discard length
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1; // Low only in the freeze scenario at the end
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic reverse_mode = 1'b0; // Start as forward bridge
  logic sec_syserr_n = 1'b1;
  logic [3:0] gpio_in = 4'hA; // Pin pattern, changed to 5 only for the second read
  logic [3:0] gpio_out, gpio_oe;
  logic sec_bus_reset_n, link_hot_reset, system_error_n;
  logic err_fatal_sel = 1'b1, serr_enable = 1'b1;
  logic err_msg, err_msg_fatal, vga_claim;
  bcg_vga_req_t vga_req = '0;
  logic ma_event = 1'b0, ma_is_read = 1'b0, ma_ta_possible = 1'b0;
  logic ma_target_abort, ma_fill_ones, ma_drop_write;
  logic [1:0] dc_pending = 2'h0;
  logic [1:0] dc_discard;
  int errors = 0;
  int checked = 0;
  // Pulse tallies: msg fatal serr claim ta ones drop discard
  int cnt [8];
  int saved [8];
  int cyc_cnt = 0;
  int t_disc = 0;
  logic [1:0] last_disc = 2'h0;
  // VGA cases, bit i of the packed masks belongs to case i
  logic [7:0] v_ctl [8] = '{8'h00, 8'h10, 8'h10, 8'h20, 8'h20, 8'h10, 8'h50, 8'h50};
  logic [31:0] v_adr [8] = '{32'h000A0000, 32'h000A0000, 32'h000A0000, 32'h000B8000,
    32'h000B8000, 32'h000013C0, 32'h000013C0, 32'h000003C0};
  logic [7:0] v_io = 8'hE0;
  logic [7:0] v_sec = 8'h0C;
  logic [7:0] v_exp = 8'hAA;

  bcg_bank #(.DT_LONG_CYC(LONG)) DUT (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .reverse_mode(reverse_mode), .sec_syserr_n(sec_syserr_n),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .sec_bus_reset_n(sec_bus_reset_n), .link_hot_reset(link_hot_reset),
    .system_error_n(system_error_n), .err_fatal_sel(err_fatal_sel),
    .serr_enable(serr_enable), .err_msg(err_msg), .err_msg_fatal(err_msg_fatal),
    .vga_req(vga_req), .vga_claim(vga_claim), .ma_event(ma_event),
    .ma_is_read(ma_is_read), .ma_ta_possible(ma_ta_possible),
    .ma_target_abort(ma_target_abort), .ma_fill_ones(ma_fill_ones),
    .ma_drop_write(ma_drop_write), .dc_pending(dc_pending), .dc_discard(dc_discard));

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  // Count every pulse cycle so scenarios compare deltas, not timing
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (err_msg === 1'b1) cnt[0] <= cnt[0] + 1;
    if (err_msg_fatal === 1'b1) cnt[1] <= cnt[1] + 1;
    if (system_error_n === 1'b0) cnt[2] <= cnt[2] + 1;
    if (vga_claim === 1'b1) cnt[3] <= cnt[3] + 1;
    if (ma_target_abort === 1'b1) cnt[4] <= cnt[4] + 1;
    if (ma_fill_ones === 1'b1) cnt[5] <= cnt[5] + 1;
    if (ma_drop_write === 1'b1) cnt[6] <= cnt[6] + 1;
    if (dc_discard !== 2'h0) begin
      cnt[7] <= cnt[7] + 1;
      t_disc <= cyc_cnt;
      last_disc <= dc_discard;
    end
  end

  // Compare and report one value
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Compare a tally delta since the last snapshot
  task automatic dchk(input string what, input int i, input int d);
    chk(what, 32'(cnt[i] - saved[i]), 32'(d));
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One classic cycle; held until ack is sampled, bounded wait
  task automatic wb_go(input logic we, input logic [7:0] adr, input logic [31:0] dat,
    output logic [31:0] rd);
    int k = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    chk("bus ack", 32'(wb_ack_o), 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] junk;
    wb_go(1'b1, adr, dat, junk);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] v;
    wb_go(1'b0, adr, 32'h00000000, v);
    chk(what, v, exp);
  endtask

  // One-cycle VGA offer
  task automatic offer(input logic io, input logic fs, input logic [31:0] a);
    @(posedge core_clk);
    vga_req <= {1'b1, io, fs, a};
    @(posedge core_clk);
    vga_req <= '0;
  endtask

  // One-cycle master abort event
  task automatic abort(input logic rd, input logic ta);
    @(posedge core_clk);
    ma_event <= 1'b1;
    ma_is_read <= rd;
    ma_ta_possible <= ta;
    @(posedge core_clk);
    ma_event <= 1'b0;
  endtask

  // Hold a completion waiting and time the discard; slack covers the output register and tally latency
  task automatic meas(input int side, input int len);
    int t0;
    int k = 0;
    @(posedge core_clk);
    t0 = cyc_cnt;
    saved = cnt;
    dc_pending <= 2'(1 << side);
    while (cnt[7] == saved[7] && k < 1300) begin
      @(posedge core_clk);
      k++;
    end
    dc_pending <= 2'h0;
    chk("discard side", 32'(last_disc), 32'(1 << side));
    chk("discard span", 32'(t_disc - t0 >= len - 2 && t_disc - t0 <= len + 3), 32'h1);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog, well past the roughly 2600 cycles the tests need
  initial begin
    #(40 * 12000);
    errors++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    idle(6);
    rd_chk("control word", BCG_OFF_CTRL, 32'hA0000000);
    gpio_in <= 4'h5;
    idle(3);
    rd_chk("gpio input", BCG_OFF_CTRL, 32'h50000000);
    gpio_in <= 4'hA;
    idle(3);
    wr(BCG_OFF_RSVD, 32'hFFFFFFFF);
    rd_chk("reserved word", BCG_OFF_RSVD, BCG_ZERO);
    wr(BCG_OFF_CTRL, 32'h00000F0C);
    rd_chk("control word", BCG_OFF_CTRL, 32'hA0000A0C);
    idle(3);
    chk("secondary reset", 32'(sec_bus_reset_n), 32'h0);
    chk("hot reset", 32'(link_hot_reset), 32'h0);
    saved = cnt;
    sec_syserr_n <= 1'b0;
    idle(8);
    sec_syserr_n <= 1'b1;
    dchk("error message", 0, 1);
    dchk("fatal message", 1, 1);
    // Forwarding off and GPIO set in one write
    wr(BCG_OFF_CTRL, 32'h00050000);
    idle(2);
    chk("gpio out", 32'(gpio_out), 32'h5);
    chk("secondary reset", 32'(sec_bus_reset_n), 32'h1);
    saved = cnt;
    sec_syserr_n <= 1'b0;
    idle(8);
    sec_syserr_n <= 1'b1;
    dchk("error message", 0, 0);
    wr(BCG_OFF_CTRL, 32'h00001000);
    idle(2);
    chk("gpio out", 32'(gpio_out), 32'h4);
    wr(BCG_OFF_CTRL, 32'h00000000);
    idle(2);
    chk("gpio out", 32'(gpio_out), 32'h4);
    wr(BCG_OFF_CTRL, 32'h03000000);
    idle(2);
    chk("gpio enable", 32'(gpio_oe), 32'h3);
    wr(BCG_OFF_CTRL, 32'h00100000);
    idle(2);
    chk("gpio enable", 32'(gpio_oe), 32'h2);
    rd_chk("gpio word", BCG_OFF_CTRL, 32'hA2244000);
    // VGA direction and decode width table
    for (int i = 0; i < 8; i++) begin
      wr(BCG_OFF_CTRL, {24'h000000, v_ctl[i]});
      saved = cnt;
      offer(v_io[i], v_sec[i], v_adr[i]);
      idle(3);
      dchk("vga claim", 3, int'(v_exp[i]));
    end
    // Master aborts hidden, then reported
    wr(BCG_OFF_CTRL, 32'h00000000);
    saved = cnt;
    abort(1'b1, 1'b1);
    abort(1'b0, 1'b1);
    idle(3);
    dchk("fill ones", 5, 1);
    dchk("drop write", 6, 1);
    dchk("target abort", 4, 0);
    wr(BCG_OFF_CTRL, 32'h00000080);
    saved = cnt;
    abort(1'b1, 1'b1);
    abort(1'b1, 1'b0);
    idle(3);
    dchk("target abort", 4, 1);
    dchk("system error", 2, 1);
    dchk("fill ones", 5, 0);
    // System error reporting disabled: no pulse
    serr_enable <= 1'b0;
    saved = cnt;
    abort(1'b1, 1'b0);
    idle(3);
    dchk("system error", 2, 0);
    serr_enable <= 1'b1;
    // Forward discard timers
    wr(BCG_OFF_CTRL, 32'h00000900);
    rd_chk("timeout bits", BCG_OFF_CTRL, 32'hA2244800);
    err_fatal_sel <= 1'b0;
    meas(0, LONG);
    dchk("error message", 0, 1);
    dchk("fatal message", 1, 0);
    rd_chk("timeout status", BCG_OFF_CTRL, 32'hA2244C00);
    wr(BCG_OFF_CTRL, 32'h00000800);
    rd_chk("timeout status", BCG_OFF_CTRL, 32'hA2244C00);
    wr(BCG_OFF_CTRL, 32'h00000400);
    rd_chk("timeout status", BCG_OFF_CTRL, 32'hA2244000);
    wr(BCG_OFF_CTRL, 32'h00000200);
    meas(1, BCG_DT_SHORT_CYC);
    // Clear status, keep the secondary short bit for the reverse check
    wr(BCG_OFF_CTRL, 32'h00000600);
    // Reverse bridge
    reverse_mode <= 1'b1;
    idle(4);
    wr(BCG_OFF_CTRL, 32'h00000008);
    idle(2);
    chk("hot reset", 32'(link_hot_reset), 32'h1);
    chk("secondary reset", 32'(sec_bus_reset_n), 32'h1);
    wr(BCG_OFF_CTRL, 32'h00000B04);
    rd_chk("reverse bits", BCG_OFF_CTRL, 32'hA2244B00);
    meas(0, BCG_DT_SHORT_CYC);
    dchk("system error", 2, 1);
    meas(1, LONG);
    // Back to forward: the primary bit set in reverse must be ignored
    reverse_mode <= 1'b0;
    idle(4);
    meas(0, LONG);
    // Frozen clock enable: a waiting completion must not time out
    idle(1);
    saved = cnt;
    clk_en <= 1'b0;
    dc_pending <= 2'h1;
    idle(LONG + 8);
    dc_pending <= 2'h0;
    idle(2);
    clk_en <= 1'b1;
    idle(2);
    dchk("frozen discard", 7, 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
